// ---- src/icat_defines.svh ----
`ifndef ICAT_DEFINES_SVH
`define ICAT_DEFINES_SVH

// Clock period in picoseconds (250 MHz).
`define ICAT_CLK_PERIOD_PS 4000

// Timing figures in their printed units.
`define ICAT_TEMP_UPDATE_MS       32
`define ICAT_CAL_RUN_US           1
`define ICAT_CAL_CAPTURE_NS       30
`define ICAT_CAL_CAPTURE_MIN_NCK  8
`define ICAT_CAL_DEFAULT_NS       50
`define ICAT_CAL_DEFAULT_MIN_NCK  3

// Derived cycle counts (least times round up, longest round down).
`define ICAT_CAL_RUN_CYC ((`ICAT_CAL_RUN_US * 1000000 + `ICAT_CLK_PERIOD_PS - 1) / `ICAT_CLK_PERIOD_PS)
`define ICAT_CAP_NS_CYC ((`ICAT_CAL_CAPTURE_NS * 1000 + `ICAT_CLK_PERIOD_PS - 1) / `ICAT_CLK_PERIOD_PS)
`define ICAT_CAL_CAPTURE_CYC ((`ICAT_CAP_NS_CYC > `ICAT_CAL_CAPTURE_MIN_NCK) ? `ICAT_CAP_NS_CYC : `ICAT_CAL_CAPTURE_MIN_NCK)
`define ICAT_DEF_NS_CYC ((`ICAT_CAL_DEFAULT_NS * 1000 + `ICAT_CLK_PERIOD_PS - 1) / `ICAT_CLK_PERIOD_PS)
`define ICAT_CAL_DEFAULT_CYC ((`ICAT_DEF_NS_CYC > `ICAT_CAL_DEFAULT_MIN_NCK) ? `ICAT_DEF_NS_CYC : `ICAT_CAL_DEFAULT_MIN_NCK)
`define ICAT_TEMP_UPDATE_CYC (`ICAT_TEMP_UPDATE_MS * 250000)

// Field positions.
`define ICAT_CAL_DEFAULT_BIT   0
`define ICAT_ADDR_TERM_LSB     4
`define ICAT_ADDR_TERM_MSB     6
`define ICAT_CLK_FORCE_BIT     3
`define ICAT_SEL_FORCE_BIT     4
`define ICAT_ADDR_DISABLE_BIT  5

// Reset values.
`define ICAT_TERM_MODE_RESET   8'h00
`define ICAT_OVERRIDE_RESET    8'h00
`define ICAT_CODE_DEFAULT      6'h20

`endif

// ---- src/icat_pkg.sv ----
package icat_pkg;
   // Calibration engine states.
   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_RUN,
      CAL_DONE
   } icat_cal_state_t;
endpackage : icat_pkg

// ---- src/icat_interval_timer.sv ----
`timescale 1ns/1ns
// Down-counter that raises done once a loaded count has elapsed.
module icat_interval_timer #(
   parameter int WIDTH = 24
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Control.
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] count,
   // Status.
   output logic                  busy,
   output logic                  done
);
   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;
   logic             done_reg;
   logic             done_next;

   initial begin
      if (WIDTH < 2) $error("icat_interval_timer: WIDTH too small");
   end

   // Reload wins over a running count so a restart always takes full time.
   always_comb begin
      cnt_next  = cnt_reg;
      done_next = 1'b0;
      if (load) begin
         cnt_next = count;
      end else if (cnt_reg != '0) begin
         cnt_next  = cnt_reg - WIDTH'(1);
         done_next = (cnt_reg == WIDTH'(1));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign busy = (cnt_reg != '0);
   assign done = done_reg;
endmodule : icat_interval_timer

// ---- src/icat_core.sv ----
// Operation
// - Temperature status refreshed at least every 32 ms
// - Accept calibration begin and capture commands
// - Calibration runs in background, commands continue
// - Capture loads computed code into drivers
// - Default bit write restores default impedance code
// - Commands execute normally during calibration interval
// - Address termination from bits 6:4, default off
// - Address termination kept in power-down states
// - Strap low leaves address lines unterminated
// - Override bits steer clock, select, address termination; clock and select only with strap low, address only with strap high
// - Strap state unchanged on power-down entry
`include "icat_defines.svh"
`timescale 1ns/1ns
module icat_core
   import icat_pkg::*;
#(
   parameter int CODE_W      = 6,
   parameter int TEMP_CYC    = `ICAT_TEMP_UPDATE_CYC,
   parameter int CAL_RUN_CYC = `ICAT_CAL_RUN_CYC
) (
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Decoded impedance calibration commands (one-cycle pulses).
   input  wire logic              impedanceCalBegin,
   input  wire logic              impedanceCalCapture,
   // Mode register write port.
   input  wire logic              modeRegWrite,
   input  wire logic [5:0]        modeRegAddr,
   input  wire logic [7:0]        modeRegData,
   // Analog calibration front end.
   input  wire logic [CODE_W-1:0] calComparatorCode,
   input  wire logic [2:0]        tempSensorCode,
   // Strap and power state.
   input  wire logic              terminationStrapPad,
   input  wire logic              powerDown,
   // Driver impedance and calibration status.
   output logic [CODE_W-1:0]      driverCode,
   output logic                   calRunning,
   output logic                   calResultReady,
   output logic                   calDefaultBusy,
   // Termination controls.
   output logic [2:0]             addrTermValue,
   output logic                   addrTermOn,
   output logic                   clockTermOn,
   output logic                   selectTermOn,
   // Temperature status.
   output logic [2:0]             tempStatus,
   output logic                   tempStatusStrobe
);
   localparam logic [5:0] CAL_MODE_ADDR  = 6'h0A;
   localparam logic [5:0] TERM_MODE_ADDR = 6'h0B;
   localparam logic [5:0] OVERRIDE_ADDR  = 6'h16;
   localparam int         TW             = $clog2(CAL_RUN_CYC + 1) + 1;

   initial begin
      if (CODE_W < 2 || CODE_W > 8) $error("icat_core: CODE_W out of range");
      if (CAL_RUN_CYC < 1 || TEMP_CYC < 1) $error("icat_core: counts must be positive");
      if (`ICAT_CAL_CAPTURE_CYC > CAL_RUN_CYC) $error("icat_core: run time too short");
   end

   icat_cal_state_t   calState_reg;
   icat_cal_state_t   calState_next;
   logic [CODE_W-1:0] resultCode_reg;
   logic [CODE_W-1:0] resultCode_next;
   logic [CODE_W-1:0] driverCode_reg;
   logic [CODE_W-1:0] driverCode_next;
   logic [7:0]        termMode_reg;
   logic [7:0]        termMode_next;
   logic [7:0]        override_reg;
   logic [7:0]        override_next;
   logic              strap_reg;
   logic              strap_next;
   logic              strapTaken_reg;
   logic              strapTaken_next;
   logic [2:0]        addrVal_reg;
   logic [2:0]        addrVal_next;
   logic              addrOn_reg;
   logic              addrOn_next;
   logic              clkOn_reg;
   logic              clkOn_next;
   logic              selOn_reg;
   logic              selOn_next;
   logic [2:0]        temp_reg;
   logic [2:0]        temp_next;
   logic              tempStb_reg;
   logic              tempStb_next;
   logic [31:0]       tempCnt_reg;
   logic [31:0]       tempCnt_next;
   logic              runBusy;
   logic              runDone;
   logic              defBusy;
   logic              defaultWrite;
   logic              termModeWrite;
   logic              overrideWrite;

   assign defaultWrite  = modeRegWrite && modeRegAddr == CAL_MODE_ADDR
                          && modeRegData[`ICAT_CAL_DEFAULT_BIT];
   assign termModeWrite = modeRegWrite && modeRegAddr == TERM_MODE_ADDR;
   assign overrideWrite = modeRegWrite && modeRegAddr == OVERRIDE_ADDR;

   icat_interval_timer #(.WIDTH(TW)) runTimer (
      .clk   (clk),
      .rst_n (rst_n),
      .load  (impedanceCalBegin && !powerDown && !defaultWrite),
      .count (TW'(CAL_RUN_CYC)),
      .busy  (runBusy),
      .done  (runDone)
   );

   icat_interval_timer #(.WIDTH(8)) defTimer (
      .clk   (clk),
      .rst_n (rst_n),
      .load  (defaultWrite),
      .count (8'(`ICAT_CAL_DEFAULT_CYC)),
      .busy  (defBusy),
      .done  ()
   );

   // Calibration engine. It never gates the command path, so ordinary
   // commands keep running while the comparator settles.
   // commands never gated
   always_comb begin
      calState_next   = calState_reg;
      resultCode_next = resultCode_reg;
      driverCode_next = driverCode_reg;
      if (impedanceCalBegin && !powerDown) begin
         calState_next = CAL_RUN;
      end else begin
         unique case (calState_reg)
            CAL_IDLE: begin
            end
            CAL_RUN: begin
               if (runDone) begin
                  resultCode_next = calComparatorCode;
                  calState_next   = CAL_DONE;
               end
            end
            CAL_DONE: begin
               if (impedanceCalCapture && !powerDown) begin
                  driverCode_next = resultCode_reg;
                  calState_next   = CAL_IDLE;
               end
            end
         endcase
      end
      if (defaultWrite) begin
         driverCode_next = CODE_W'(`ICAT_CODE_DEFAULT);
         calState_next   = CAL_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         calState_reg   <= CAL_IDLE;
         resultCode_reg <= CODE_W'(`ICAT_CODE_DEFAULT);
         driverCode_reg <= CODE_W'(`ICAT_CODE_DEFAULT);
      end else begin
         calState_reg   <= calState_next;
         resultCode_reg <= resultCode_next;
         driverCode_reg <= driverCode_next;
      end
   end

   // Mode registers and the strap, caught once after reset release.
   always_comb begin
      termMode_next   = termMode_reg;
      override_next   = override_reg;
      strap_next      = strap_reg;
      strapTaken_next = 1'b1;
      if (termModeWrite) termMode_next = modeRegData;
      if (overrideWrite) override_next = modeRegData;
      if (!strapTaken_reg) strap_next = terminationStrapPad;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         termMode_reg   <= `ICAT_TERM_MODE_RESET;
         override_reg   <= `ICAT_OVERRIDE_RESET;
         strap_reg      <= 1'b0;
         strapTaken_reg <= 1'b0;
      end else begin
         termMode_reg   <= termMode_next;
         override_reg   <= override_next;
         strap_reg      <= strap_next;
         strapTaken_reg <= strapTaken_next;
      end
   end

   // Termination decode. Power-down is deliberately absent from it.
   always_comb begin
      addrVal_next = termMode_reg[`ICAT_ADDR_TERM_MSB:`ICAT_ADDR_TERM_LSB];
      addrOn_next  = 1'b0;
      clkOn_next   = 1'b0;
      selOn_next   = 1'b0;
      if (addrVal_next != 3'b000) begin
         if (strap_reg) begin
            clkOn_next  = 1'b1;
            selOn_next  = 1'b1;
            addrOn_next = !override_reg[`ICAT_ADDR_DISABLE_BIT];
         end else begin
            addrOn_next = 1'b0;
            clkOn_next  = override_reg[`ICAT_CLK_FORCE_BIT];
            selOn_next  = override_reg[`ICAT_SEL_FORCE_BIT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addrVal_reg <= 3'b000;
         addrOn_reg  <= 1'b0;
         clkOn_reg   <= 1'b0;
         selOn_reg   <= 1'b0;
      end else begin
         addrVal_reg <= addrVal_next;
         addrOn_reg  <= addrOn_next;
         clkOn_reg   <= clkOn_next;
         selOn_reg   <= selOn_next;
      end
   end

   // Temperature status refresh; runs in every power state.
   always_comb begin
      temp_next    = temp_reg;
      tempStb_next = 1'b0;
      tempCnt_next = tempCnt_reg + 32'd1;
      if (tempCnt_reg >= 32'(TEMP_CYC - 1)) begin
         tempCnt_next = 32'd0;
         temp_next    = tempSensorCode;
         tempStb_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         temp_reg    <= 3'b000;
         tempStb_reg <= 1'b0;
         tempCnt_reg <= 32'd0;
      end else begin
         temp_reg    <= temp_next;
         tempStb_reg <= tempStb_next;
         tempCnt_reg <= tempCnt_next;
      end
   end

   // Status flags registered so every output leaves a flip-flop.
   logic runBusy_reg;
   logic ready_reg;
   logic defBusy_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         runBusy_reg <= 1'b0;
         ready_reg   <= 1'b0;
         defBusy_reg <= 1'b0;
      end else begin
         runBusy_reg <= runBusy;
         ready_reg   <= (calState_next == CAL_DONE);
         defBusy_reg <= defBusy;
      end
   end

   assign driverCode       = driverCode_reg;
   assign calRunning       = runBusy_reg;
   assign calResultReady   = ready_reg;
   assign calDefaultBusy   = defBusy_reg;
   assign addrTermValue    = addrVal_reg;
   assign addrTermOn       = addrOn_reg;
   assign clockTermOn      = clkOn_reg;
   assign selectTermOn     = selOn_reg;
   assign tempStatus       = temp_reg;
   assign tempStatusStrobe = tempStb_reg;
endmodule : icat_core

// ---- tb/icat_core_checker.sv ----
`timescale 1ns/1ns
// Ties each calibration output and termination enable to the command that caused it.
module icat_core_checker #(
   parameter int TEMP_CYC    = 100,
   parameter int CAL_RUN_CYC = 20
) (
   // Clock, reset and commands.
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       impedanceCalBegin,
   input wire logic       impedanceCalCapture,
   input wire logic       modeRegWrite,
   input wire logic [5:0] modeRegAddr,
   input wire logic [7:0] modeRegData,
   input wire logic       terminationStrapPad,
   input wire logic       powerDown,
   // Observed outputs.
   input wire logic [5:0] driverCode,
   input wire logic       calRunning,
   input wire logic       calResultReady,
   input wire logic       calDefaultBusy,
   input wire logic       addrTermOn,
   input wire logic       clockTermOn,
   input wire logic       selectTermOn,
   input wire logic       tempStatusStrobe
);
   logic [15:0] runCnt_reg;
   logic [15:0] runCnt_next;
   logic [15:0] gap_reg;
   logic [15:0] gap_next;
   // Run length and refresh spacing are counted, since both exceed a repetition.
   always_comb begin
      runCnt_next = calRunning ? runCnt_reg + 16'h0001 : 16'h0000;
      gap_next    = tempStatusStrobe ? 16'h0000 : gap_reg + 16'h0001;
   end
   always_ff @(posedge clk) begin
      runCnt_reg <= rst_n ? runCnt_next : 16'h0000;
      gap_reg    <= rst_n ? gap_next : 16'h0000;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_run_starts:
   assert property (impedanceCalBegin && !powerDown && !modeRegWrite |-> ##2 calRunning)
      else $error("run flag missing after begin");
   chk_run_length:
   assert property ($fell(calRunning) |-> runCnt_reg >= CAL_RUN_CYC - 1
                    && runCnt_reg <= CAL_RUN_CYC + 2)
      else $error("run length off");
   chk_result_ready:
   assert property ($fell(calRunning) |-> ##[0:2] calResultReady)
      else $error("no result after run");
   chk_capture_clears:
   assert property (impedanceCalCapture && calResultReady && !powerDown && !modeRegWrite
                    |=> !calResultReady)
      else $error("result flag kept after capture");
   chk_capture_refused:
   assert property (impedanceCalCapture && !calResultReady && !modeRegWrite
                    && !$past(modeRegWrite) |=> $stable(driverCode))
      else $error("code moved without result");
   chk_default_code:
   assert property (modeRegWrite && modeRegAddr == 6'h0A && modeRegData[0]
                    |=> driverCode == 6'h20 ##1 calDefaultBusy [*8])
      else $error("default code or busy wrong");
   chk_term_off:
   assert property (modeRegWrite && modeRegAddr == 6'h0B && modeRegData[6:4] == 3'h0
                    |-> ##2 !addrTermOn && !clockTermOn && !selectTermOn)
      else $error("termination on while disabled");
   chk_strap_high:
   assert property (modeRegWrite && modeRegAddr == 6'h0B && modeRegData[6:4] != 3'h0
                    && terminationStrapPad |-> ##2 clockTermOn && selectTermOn)
      else $error("clock or select unterminated");
   chk_temp_period:
   assert property (gap_reg <= TEMP_CYC)
      else $error("temperature refresh late");
endmodule : icat_core_checker

bind icat_core icat_core_checker #(.TEMP_CYC(TEMP_CYC), .CAL_RUN_CYC(CAL_RUN_CYC)) chk_inst (
   .clk, .rst_n, .impedanceCalBegin, .impedanceCalCapture, .modeRegWrite, .modeRegAddr,
   .modeRegData, .terminationStrapPad, .powerDown, .driverCode, .calRunning,
   .calResultReady, .calDefaultBusy, .addrTermOn, .clockTermOn, .selectTermOn,
   .tempStatusStrobe);

// ---- tb/icat_ctrl_model.sv ----
`timescale 1ns/1ns
// Controller pacing: capture is allowed only once the run time has passed.
module icat_ctrl_model #(
   parameter int RUN_CYC = 20
) (
   // Clock, reset and observed commands.
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic calBegin,
   input  wire logic powerDown,
   // Pacing output.
   output logic      captureOk
);
   int waitCnt_reg;
   int waitCnt_next;
   always_comb begin
      waitCnt_next = calBegin ? 0 : waitCnt_reg + int'(waitCnt_reg < RUN_CYC + 4);
   end
   always_ff @(posedge clk) begin
      waitCnt_reg <= rst_n ? waitCnt_next : 0;
   end
   // one rank only, so no shared resistor or training order.
   // outside power-down; no data writes leave termination on.
   assign captureOk = rst_n && !powerDown && waitCnt_reg > RUN_CYC + 2;
endmodule : icat_ctrl_model

// ---- tb/icat_core_test.sv ----
`timescale 1ns/1ns
module icat_core_test;
   localparam int TEMP = 100;
   localparam int RUN  = 20;
   logic       clk = 1'b0, rst_n = 1'b0, strap = 1'b0, powerDown = 1'b0;
   logic       calBegin = 1'b0, calCapture = 1'b0, mrWrite = 1'b0;
   logic [5:0] mrAddr = 6'h00, compCode = 6'h00, driverCode;
   logic [7:0] mrData = 8'h00, m11, m22;
   logic [2:0] sensor = 3'h0, termValue, tempStatus;
   logic       calRunning, calReady, defBusy, addrOn, clkOn, selOn, tempStrobe, captureOk;
   logic [31:0] r;
   int         seed = 32'h8a95fc06, n_mismatch = 0, comparisons = 0, i, k, s;
   // Free-running clock at 250 MHz.
   always #2 clk = ~clk;
   icat_core #(.TEMP_CYC(TEMP), .CAL_RUN_CYC(RUN)) icat_core_inst (
      .clk(clk), .rst_n(rst_n), .impedanceCalBegin(calBegin), .impedanceCalCapture(calCapture),
      .modeRegWrite(mrWrite), .modeRegAddr(mrAddr), .modeRegData(mrData),
      .calComparatorCode(compCode), .tempSensorCode(sensor), .terminationStrapPad(strap),
      .powerDown(powerDown), .driverCode(driverCode), .calRunning(calRunning),
      .calResultReady(calReady), .calDefaultBusy(defBusy), .addrTermValue(termValue),
      .addrTermOn(addrOn), .clockTermOn(clkOn), .selectTermOn(selOn),
      .tempStatus(tempStatus), .tempStatusStrobe(tempStrobe));
   icat_ctrl_model #(.RUN_CYC(RUN)) icat_ctrl_model_inst (.clk(clk), .rst_n(rst_n),
      .calBegin(calBegin), .powerDown(powerDown), .captureOk(captureOk));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (exp !== got) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic test_done();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done
   task automatic mrw(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      mrWrite = 1'b1;
      mrAddr  = a;
      mrData  = d;
      @(negedge clk);
      mrWrite = 1'b0;
   endtask : mrw
   // One-cycle begin or capture pulse.
   task automatic cmd(input logic cap);
      @(negedge clk);
      calCapture = cap;
      calBegin   = ~cap;
      @(negedge clk);
      calCapture = 1'b0;
      calBegin   = 1'b0;
   endtask : cmd
   // Expected address, clock and select termination enables.
   function automatic logic [2:0] termExp(input logic [7:0] a, input logic [7:0] b,
                                          input logic st);
      if (a[6:4] == 3'h0) return 3'h0;
      if (!st) return {1'b0, b[3], b[4]};
      return {~b[5], 2'b11};
   endfunction : termExp
   task automatic termCheck();
      repeat (2) @(negedge clk);
      chk("termOn", {5'h00, termExp(m11, m22, strap)}, {5'h00, addrOn, clkOn, selOn});
      chk("termValue", {5'h00, m11[6:4]}, {5'h00, termValue});
   endtask : termCheck
   initial begin
      for (s = 0; s < 2; s++) begin
         @(negedge clk);
         rst_n = 1'b0;
         strap = s[0];
         repeat (20) @(negedge clk);
         rst_n = 1'b1;
         chk("codeAfterReset", 8'h20, {2'b00, driverCode});
         // Every override combination, with power-down toggling underneath.
         for (i = 0; i < 24; i++) begin
            r = $random(seed);
            // pull-up point is never written, so no forbidden pairing arises.
            m11 = (i < 3) ? {r[7], 3'h0, r[3:0]} : r[15:8];
            m22 = {r[23:22], i[2:0], r[18:16]};
            powerDown = r[24];
            mrw(6'h0B, m11);
            mrw(6'h16, m22);
            termCheck();
         end
      end
      powerDown = 1'b0;
      for (i = 0; i < 3; i++) begin
         powerDown = 1'b1;
         cmd(1'b0);
         powerDown = 1'b0;
         @(negedge clk);
         chk("runPowerDown", 8'h00, {7'h00, calRunning});
         r = $random(seed);
         compCode = r[5:0];
         cmd(1'b0);
         cmd(1'b1);
         chk("codeEarly", 8'h20, {2'b00, driverCode});
         r = $random(seed);
         m22 = r[7:0];
         mrw(6'h16, m22);
         termCheck();
         for (k = 0; k < 100 && !(calReady === 1'b1 && captureOk); k++) @(negedge clk);
         chk("ready", 8'h01, {7'h00, calReady});
         powerDown = 1'b1;
         cmd(1'b1);
         chk("codePowerDown", 8'h20, {2'b00, driverCode});
         powerDown = 1'b0;
         cmd(1'b1);
         @(negedge clk);
         chk("codeLatched", {2'b00, compCode}, {2'b00, driverCode});
         repeat (8) @(negedge clk);
         mrw(6'h0A, 8'h01);
         repeat (2) @(negedge clk);
         chk("codeDefault", 8'h41, {1'b0, driverCode, defBusy});
         for (k = 0; k < 30 && defBusy !== 1'b0; k++) @(negedge clk);
      end
      r = $random(seed);
      sensor = r[2:0];
      s = 0;
      for (k = 0; k < 3 * TEMP && s < 2; k++) begin
         @(negedge clk);
         s += int'(tempStrobe);
      end
      chk("tempStrobes", 8'h02, 8'(s));
      chk("tempStatus", {5'h00, sensor}, {5'h00, tempStatus});
      test_done();
   end
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      test_done();
   end
endmodule : icat_core_test
